// file: hw/uenpc_top.sv
// Endpoint handshake and data-toggle control with its register slave.
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/10ps

// Functional notes
// RULE1 - With NAK flag set, OUT data is refused despite free receive space; flag resets low.
// RULE2 - With NAK flag set, non-synchronous IN endpoints send no data packets.
// RULE3 - With NAK flag set, synchronous IN endpoints answer IN with zero-length data.
// RULE4 - SETUP packets are always acknowledged, whatever the NAK flag.
// RULE5 - Interrupt and bulk IN endpoints show next data PID, zero DATA0, one DATA1.
// RULE6 - Software sets the first PID through force-zero and force-one commands.
// RULE7 - On synchronous IN endpoints the same bit shows even or odd frame.
// RULE8 - NAK flag sets on software request or on the controller's own decision.
// RULE9 - With NAK flag clear, handshakes follow the endpoint FIFO fill state.
// RULE10 - Each acknowledged interrupt or bulk IN transaction toggles the data PID.
module uenpc_top (
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   input  wire logic [3:0]             avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   output logic      [31:0]            avs_readdata,
   output logic                        avs_waitrequest,
   input  wire logic                   tok_valid,
   input  wire uenpc_pkg::uenpc_tok_t  tok_kind,
   input  wire logic                   rx_has_room,
   input  wire logic                   tx_has_data,
   input  wire logic                   core_nak_req,
   input  wire logic                   host_ack,
   input  wire logic                   host_timeout,
   output uenpc_pkg::uenpc_rsp_t       rsp_code,
   output logic                        rsp_valid,
   output logic                        rsp_data_pid,
   output logic                        rx_accept
);

   uenpc_cfg_if cfg ();

   logic                     sw_nak_set;
   logic                     sw_nak_clr;
   logic                     nak_q;
   logic                     is_sync;
   logic                     toggled_ep;
   uenpc_pkg::uenpc_state_t  state_q;
   uenpc_pkg::uenpc_rsp_t    rsp_d;
   uenpc_pkg::uenpc_rsp_t    rsp_q;
   logic                     rsp_valid_q;
   logic                     pid_q;
   logic                     accept_d;
   logic                     accept_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Register slave and toggle keeper.
   uenpc_regs u_regs (
      .clk_sys         (clk_sys),
      .rst             (rst),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .sw_nak_set      (sw_nak_set),
      .sw_nak_clr      (sw_nak_clr),
      .cfg             (cfg.regs)
   );

   uenpc_toggle u_toggle (
      .clk_sys (clk_sys),
      .rst     (rst),
      .cfg     (cfg.tog)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Set by software or the controller; a set in the same cycle beats a clear.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         nak_q <= uenpc_pkg::NAK_RESET; // RULE1
      end else if (sw_nak_set | core_nak_req) begin
         nak_q <= 1'b1; // RULE8
      end else if (sw_nak_clr) begin
         nak_q <= 1'b0;
      end
   end

   assign cfg.nak_handshake_flag = nak_q;
   assign is_sync    = (cfg.ep_type == uenpc_pkg::EP_SYNC);
   assign toggled_ep = cfg.is_in &&
                       (cfg.ep_type == uenpc_pkg::EP_BULK || cfg.ep_type == uenpc_pkg::EP_INTR);

   ////////////////////////////////////////////////////////////////////////////////
   // Response selection for each token.
   always_comb begin
      rsp_d    = uenpc_pkg::UENPC_RSP_NONE;
      accept_d = 1'b0;
      if (tok_kind == uenpc_pkg::UENPC_TOK_SETUP) begin
         rsp_d    = uenpc_pkg::UENPC_RSP_ACK; // RULE4
         accept_d = 1'b1;
      end else if (tok_kind == uenpc_pkg::UENPC_TOK_OUT) begin
         if (nak_q || !rx_has_room) begin
            rsp_d = uenpc_pkg::UENPC_RSP_NAK; // RULE1
         end else begin
            rsp_d    = uenpc_pkg::UENPC_RSP_ACK; // RULE9
            accept_d = 1'b1;
         end
      end else if (tok_kind == uenpc_pkg::UENPC_TOK_IN) begin
         if (nak_q && is_sync) begin
            rsp_d = uenpc_pkg::UENPC_RSP_ZLP; // RULE3
         end else if (nak_q) begin
            rsp_d = uenpc_pkg::UENPC_RSP_NAK; // RULE2
         end else if (tx_has_data) begin
            rsp_d = uenpc_pkg::UENPC_RSP_DATA; // RULE9
         end else if (is_sync) begin
            rsp_d = uenpc_pkg::UENPC_RSP_ZLP;
         end else begin
            rsp_d = uenpc_pkg::UENPC_RSP_NAK; // RULE9
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer: a data answer on a non-synchronous endpoint waits for the host handshake or a timeout.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= uenpc_pkg::UENPC_IDLE;
      end else begin
         case (state_q)
            uenpc_pkg::UENPC_IDLE: begin
               if (tok_valid && rsp_d == uenpc_pkg::UENPC_RSP_DATA && !is_sync) begin
                  state_q <= uenpc_pkg::UENPC_WAIT_HS;
               end
            end
            uenpc_pkg::UENPC_WAIT_HS: begin
               if (host_ack || host_timeout) begin
                  state_q <= uenpc_pkg::UENPC_IDLE;
               end
            end
            default: begin
               state_q <= uenpc_pkg::UENPC_IDLE;
            end
         endcase
      end
   end

   // Toggle only on an acknowledged interrupt or bulk IN data packet.
   assign cfg.toggle_advance = (state_q == uenpc_pkg::UENPC_WAIT_HS) && host_ack &&
                               toggled_ep; // RULE10

   ////////////////////////////////////////////////////////////////////////////////
   // Registered answer, one cycle after the token; tokens are ignored while waiting.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rsp_q       <= uenpc_pkg::UENPC_RSP_NONE;
         rsp_valid_q <= 1'b0;
         pid_q       <= 1'b0;
         accept_q    <= 1'b0;
      end else begin
         rsp_valid_q <= tok_valid && state_q == uenpc_pkg::UENPC_IDLE;
         accept_q    <= tok_valid && state_q == uenpc_pkg::UENPC_IDLE && accept_d;
         if (tok_valid && state_q == uenpc_pkg::UENPC_IDLE) begin
            rsp_q <= rsp_d;
            pid_q <= cfg.endpoint_data_toggle; // RULE5
         end
      end
   end

   assign rsp_code     = rsp_q;
   assign rsp_valid    = rsp_valid_q;
   assign rsp_data_pid = pid_q;
   assign rx_accept    = accept_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks on the handshake choices.
   sequence tok_seen_s;
      tok_valid && state_q == uenpc_pkg::UENPC_IDLE;
   endsequence

   out_nak_refuse_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE1
      tok_seen_s and (nak_q && tok_kind == uenpc_pkg::UENPC_TOK_OUT) |=> !rx_accept
      && rsp_code == uenpc_pkg::UENPC_RSP_NAK) else $error("OUT taken under NAK");
   in_nak_stop_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE2
      tok_seen_s and (nak_q && !is_sync && tok_kind == uenpc_pkg::UENPC_TOK_IN)
      |=> rsp_code == uenpc_pkg::UENPC_RSP_NAK) else $error("IN data sent under NAK");
   sync_zlp_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE3
      tok_seen_s and (nak_q && is_sync && tok_kind == uenpc_pkg::UENPC_TOK_IN)
      |=> rsp_code == uenpc_pkg::UENPC_RSP_ZLP) else $error("no zero-length packet");
   setup_ack_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE4
      tok_seen_s and (tok_kind == uenpc_pkg::UENPC_TOK_SETUP) |=> rsp_valid
      && rsp_code == uenpc_pkg::UENPC_RSP_ACK && rx_accept) else $error("SETUP not acked");
   nak_set_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE8
      core_nak_req || sw_nak_set |=> nak_q) else $error("NAK flag not set");
   out_ack_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE9
      tok_seen_s and (!nak_q && rx_has_room && tok_kind == uenpc_pkg::UENPC_TOK_OUT)
      |=> rsp_code == uenpc_pkg::UENPC_RSP_ACK) else $error("OUT not acked");
   // The answered packet carries the PID that the status bit showed when the token came.
   pid_show_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE5
      tok_seen_s and (toggled_ep && tok_kind == uenpc_pkg::UENPC_TOK_IN)
      |=> rsp_data_pid == $past(cfg.endpoint_data_toggle))
      else $error("answer does not carry the PID");
   frame_show_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE7
      tok_seen_s and (cfg.is_in && is_sync && tok_kind == uenpc_pkg::UENPC_TOK_IN)
      |=> rsp_data_pid == $past(cfg.even_odd_frame_select))
      else $error("answer does not carry frame parity");
   // A token that arrives while a handshake is awaited gets no answer at all.
   busy_ignore_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE10
      tok_valid && state_q == uenpc_pkg::UENPC_WAIT_HS |=> !rsp_valid)
      else $error("token answered while waiting");

endmodule

// file: inc/uenpc_pkg.sv
// Package with register map, field positions, codes and states of the endpoint handshake control.
package uenpc_pkg;

   // Register byte offsets on the Avalon-MM slave.
   localparam logic [3:0] CTRL_OFFSET   = 4'h0;
   localparam logic [3:0] STATUS_OFFSET = 4'h4;

   // Control register field positions (write side).
   localparam int CTRL_NAK_SET_BIT    = 0;
   localparam int CTRL_NAK_CLR_BIT    = 1;
   localparam int CTRL_FORCE_ZERO_BIT = 2;
   localparam int CTRL_FORCE_ONE_BIT  = 3;
   localparam int CTRL_FRAME_ODD_BIT  = 4;
   localparam int CTRL_TYPE_LSB       = 8;
   localparam int CTRL_TYPE_MSB       = 9;
   localparam int CTRL_DIR_IN_BIT     = 10;

   // Status register field positions.
   localparam int STAT_TOGGLE_BIT = 16;
   localparam int STAT_NAK_BIT    = 17;

   // Reset values.
   localparam logic       NAK_RESET    = 1'b0;
   localparam logic       TOGGLE_RESET = 1'b0;
   localparam logic [1:0] TYPE_RESET   = 2'h0;

   // Endpoint transfer types.
   localparam logic [1:0] EP_CONTROL = 2'h0;
   localparam logic [1:0] EP_SYNC    = 2'h1;
   localparam logic [1:0] EP_BULK    = 2'h2;
   localparam logic [1:0] EP_INTR    = 2'h3;

   // Token and handshake codes on the protocol-engine side.
   typedef enum logic [1:0] {UENPC_TOK_OUT, UENPC_TOK_IN, UENPC_TOK_SETUP} uenpc_tok_t;
   typedef enum logic [2:0] {
      UENPC_RSP_NONE, UENPC_RSP_ACK, UENPC_RSP_NAK, UENPC_RSP_DATA, UENPC_RSP_ZLP
   } uenpc_rsp_t;

   // Transaction sequencer states.
   typedef enum logic [1:0] {UENPC_IDLE, UENPC_WAIT_HS} uenpc_state_t;

endpackage

// file: inc/uenpc_cfg_if.sv
// Interface carrying endpoint configuration and toggle state between the modules.
`timescale 1ns/10ps
interface uenpc_cfg_if;
   logic       nak_handshake_flag;
   logic       is_in;
   logic [1:0] ep_type;
   logic       endpoint_data_toggle;
   logic       even_odd_frame_select;
   logic       force_toggle_zero;
   logic       force_toggle_one;
   logic       toggle_advance;

   modport regs (
      output is_in, ep_type, even_odd_frame_select, force_toggle_zero, force_toggle_one,
      input  nak_handshake_flag, endpoint_data_toggle
   );
   modport tog (
      input  is_in, ep_type, even_odd_frame_select, force_toggle_zero, force_toggle_one,
      input  toggle_advance,
      output endpoint_data_toggle
   );
   modport core (
      input  nak_handshake_flag, is_in, ep_type, endpoint_data_toggle,
      output toggle_advance
   );
endinterface

// file: hw/uenpc_regs.sv
// Avalon-MM slave holding the endpoint control bits and returning status.
`timescale 1ns/10ps
module uenpc_regs (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic             sw_nak_set,
   output logic             sw_nak_clr,
   uenpc_cfg_if.regs        cfg
);

   logic       ack_q;
   logic       is_in_q;
   logic [1:0] type_q;
   logic       frame_q;
   logic       wr_go;

   ////////////////////////////////////////////////////////////////////////////////
   // Each access waits one cycle, so waitrequest drops in the second cycle.
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign wr_go           = avs_write & ack_q & (avs_address == uenpc_pkg::CTRL_OFFSET);

   // Acknowledge toggles back so back-to-back requests each wait once.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
      end
   end

   // Configuration fields written by software.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         is_in_q <= 1'b0;
         type_q  <= uenpc_pkg::TYPE_RESET;
         frame_q <= 1'b0;
      end else if (wr_go) begin
         is_in_q <= avs_writedata[uenpc_pkg::CTRL_DIR_IN_BIT];
         type_q  <= avs_writedata[uenpc_pkg::CTRL_TYPE_MSB:uenpc_pkg::CTRL_TYPE_LSB];
         frame_q <= avs_writedata[uenpc_pkg::CTRL_FRAME_ODD_BIT];
      end
   end

   // Self-clearing command strobes, one cycle at the accepting edge.
   assign sw_nak_set            = wr_go & avs_writedata[uenpc_pkg::CTRL_NAK_SET_BIT];
   assign sw_nak_clr            = wr_go & avs_writedata[uenpc_pkg::CTRL_NAK_CLR_BIT];
   assign cfg.force_toggle_zero = wr_go & avs_writedata[uenpc_pkg::CTRL_FORCE_ZERO_BIT];
   assign cfg.force_toggle_one  = wr_go & avs_writedata[uenpc_pkg::CTRL_FORCE_ONE_BIT];
   assign cfg.is_in                 = is_in_q;
   assign cfg.ep_type               = type_q;
   assign cfg.even_odd_frame_select = frame_q;

   // Read data registered; unmapped addresses read zero.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         avs_readdata <= 32'h0;
      end else if (avs_read & ~ack_q) begin
         avs_readdata <= 32'h0;
         if (avs_address == uenpc_pkg::CTRL_OFFSET) begin
            avs_readdata[uenpc_pkg::CTRL_DIR_IN_BIT]    <= is_in_q;
            avs_readdata[uenpc_pkg::CTRL_TYPE_MSB:uenpc_pkg::CTRL_TYPE_LSB] <= type_q;
            avs_readdata[uenpc_pkg::CTRL_FRAME_ODD_BIT] <= frame_q;
         end else if (avs_address == uenpc_pkg::STATUS_OFFSET) begin
            avs_readdata[uenpc_pkg::STAT_NAK_BIT]    <= cfg.nak_handshake_flag;
            avs_readdata[uenpc_pkg::STAT_TOGGLE_BIT] <= cfg.endpoint_data_toggle;
         end
      end
   end

endmodule

// file: hw/uenpc_toggle.sv
// Data toggle keeper for interrupt and bulk IN endpoints, frame parity for synchronous ones.
`timescale 1ns/10ps
module uenpc_toggle (
   input  wire logic clk_sys,
   input  wire logic rst,
   uenpc_cfg_if.tog  cfg
);

   logic pid_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Force commands win over the automatic toggle after an acknowledged packet.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pid_q <= uenpc_pkg::TOGGLE_RESET;
      end else if (cfg.force_toggle_zero) begin
         pid_q <= 1'b0; // RULE6
      end else if (cfg.force_toggle_one) begin
         pid_q <= 1'b1; // RULE6
      end else if (cfg.toggle_advance) begin
         pid_q <= ~pid_q; // RULE10
      end
   end

   // The same status bit shows frame parity on synchronous IN endpoints.
   assign cfg.endpoint_data_toggle = (cfg.is_in && cfg.ep_type == uenpc_pkg::EP_SYNC) ?
                                     cfg.even_odd_frame_select : pid_q; // RULE5 RULE7

   toggle_step_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE10
      cfg.toggle_advance && !cfg.force_toggle_zero && !cfg.force_toggle_one
      |=> pid_q != $past(pid_q)) else $error("toggle did not advance");
   force_zero_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE6
      cfg.force_toggle_zero |=> !pid_q) else $error("force to zero failed");

endmodule

// file: tb/uenpc_host_model.sv
// Behavioural host that issues tokens and returns handshakes after data packets.
`timescale 1ns/10ps
module uenpc_host_model (
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire uenpc_pkg::uenpc_rsp_t rsp_code,
   input  wire logic                  rsp_valid,
   input  wire logic                  rsp_data_pid,
   input  wire logic                  rx_accept,
   output logic                       tok_valid,
   output uenpc_pkg::uenpc_tok_t      tok_kind,
   output logic                       host_ack,
   output logic                       host_timeout
);
   // Handshake mode: 0 acknowledge, 1 let it time out, 2 none (synchronous endpoint).
   int hs_mode = 0;
   int hs_delay = 0;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Idle levels at time zero.
   initial begin
      tok_valid = 1'b0;
      tok_kind = uenpc_pkg::UENPC_TOK_OUT;
      host_ack = 1'b0;
      host_timeout = 1'b0;
   end

   // Sends one token and returns what the device answered one cycle after it was taken.
   task automatic send_token(input uenpc_pkg::uenpc_tok_t k, output logic [5:0] seen);
      @(posedge clk_sys);
      tok_valid <= 1'b1;
      tok_kind <= k;
      @(posedge clk_sys);
      tok_valid <= 1'b0;
      tok_kind <= uenpc_pkg::uenpc_tok_t'(~k); // The kind lines do not hold once released.
      @(posedge clk_sys);
      seen = {rsp_valid, rsp_code, rx_accept, rsp_data_pid};
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////
   // After a data packet the host answers with ACK or lets it time out, promptly or late.
   always begin
      @(posedge clk_sys);
      if (!rst && rsp_valid === 1'b1 && rsp_code === uenpc_pkg::UENPC_RSP_DATA &&
          hs_mode != 2) begin
         repeat (hs_delay) @(posedge clk_sys);
         host_ack <= (hs_mode == 0);
         host_timeout <= (hs_mode == 1);
         @(posedge clk_sys);
         host_ack <= 1'b0;
         host_timeout <= 1'b0;
      end
   end
endmodule

// file: tb/tb.sv
// Self-checking bench for the endpoint handshake and data-toggle control.
`timescale 1ns/10ps
module tb;
   logic                  clk_sys, rst, avs_read, avs_write, avs_waitrequest;
   logic [3:0]            avs_address;
   logic [31:0]           avs_writedata, avs_readdata, rd;
   logic                  tok_valid, rx_has_room, tx_has_data, core_nak_req;
   logic                  host_ack, host_timeout, rsp_valid, rsp_data_pid, rx_accept;
   uenpc_pkg::uenpc_tok_t tok_kind;
   uenpc_pkg::uenpc_rsp_t rsp_code;
   int                    err_total = 0;
   int                    cmp_count = 0;

   uenpc_top dut_u (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tok_valid(tok_valid),
      .tok_kind(tok_kind), .rx_has_room(rx_has_room), .tx_has_data(tx_has_data),
      .core_nak_req(core_nak_req), .host_ack(host_ack), .host_timeout(host_timeout),
      .rsp_code(rsp_code), .rsp_valid(rsp_valid), .rsp_data_pid(rsp_data_pid),
      .rx_accept(rx_accept));
   uenpc_host_model host_u (.clk_sys(clk_sys), .rst(rst), .rsp_code(rsp_code),
      .rsp_valid(rsp_valid), .rsp_data_pid(rsp_data_pid), .rx_accept(rx_accept),
      .tok_valid(tok_valid), .tok_kind(tok_kind), .host_ack(host_ack),
      .host_timeout(host_timeout));

   ////////////////////////////////////////////////////////////////////////////////////////
   // Counts a comparison and reports a mismatch at once.
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One bus cycle held until waitrequest is sampled low; read data is taken at that edge.
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) chk("bus answer", 32'h0, 32'h1);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   // Control word: direction, type, odd frame and the four command strobes.
   function automatic logic [31:0] cw(logic [1:0] t, logic i, logic odd, logic [3:0] s);
      return {21'h0, i, t, 3'h0, odd, s};
   endfunction

   // Reads status and compares flag and toggle bits.
   task automatic stat(input logic nak, input logic pid);
      bus(1'b0, uenpc_pkg::STATUS_OFFSET, 32'h0);
      chk("status", {14'h0, nak, pid, 16'h0}, rd);
   endtask

   // Sends a token and compares the answer; the PID only matters for data and zero-length answers.
   task automatic tok(input uenpc_pkg::uenpc_tok_t k, input uenpc_pkg::uenpc_rsp_t c,
                      input logic acc, input logic pid);
      logic [5:0] s;
      host_u.send_token(k, s);
      if (c != uenpc_pkg::UENPC_RSP_DATA && c != uenpc_pkg::UENPC_RSP_ZLP) pid = s[0];
      chk("answer", {26'h0, 1'b1, c, acc, pid}, {26'h0, s});
      repeat (6) @(posedge clk_sys);
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////
   // Reset values, readback and an unmapped place.
   task automatic t_reset();
      stat(1'b0, 1'b0);
      bus(1'b0, uenpc_pkg::CTRL_OFFSET, 32'h0);
      chk("control", 32'h0, rd);
      bus(1'b0, 4'h8, 32'h0);
      chk("unmapped", 32'h0, rd);
   endtask

   // OUT and SETUP handshakes with the flag clear and set.
   task automatic t_out();
      bus(1'b1, 4'h0, cw(uenpc_pkg::EP_BULK, 1'b0, 1'b0, 4'h0));
      rx_has_room <= 1'b1;
      tok(uenpc_pkg::UENPC_TOK_OUT, uenpc_pkg::UENPC_RSP_ACK, 1'b1, 1'b0);
      rx_has_room <= 1'b0;
      tok(uenpc_pkg::UENPC_TOK_OUT, uenpc_pkg::UENPC_RSP_NAK, 1'b0, 1'b0);
      tok(uenpc_pkg::UENPC_TOK_SETUP, uenpc_pkg::UENPC_RSP_ACK, 1'b1, 1'b0);
      bus(1'b1, 4'h0, cw(uenpc_pkg::EP_BULK, 1'b0, 1'b0, 4'h1));
      stat(1'b1, 1'b0);
      rx_has_room <= 1'b1;
      tok(uenpc_pkg::UENPC_TOK_OUT, uenpc_pkg::UENPC_RSP_NAK, 1'b0, 1'b0);
      tok(uenpc_pkg::UENPC_TOK_SETUP, uenpc_pkg::UENPC_RSP_ACK, 1'b1, 1'b0);
      bus(1'b1, 4'h0, cw(uenpc_pkg::EP_BULK, 1'b0, 1'b0, 4'h2));
      stat(1'b0, 1'b0);
   endtask

   // Toggle forcing and advancing on bulk and interrupt IN, then the controller's own NAK.
   task automatic t_toggle(input logic [1:0] t, input int dly);
      host_u.hs_delay = dly;
      bus(1'b1, 4'h0, cw(t, 1'b1, 1'b0, 4'h8));
      stat(1'b0, 1'b1);
      bus(1'b0, 4'h0, 32'h0);
      chk("control", cw(t, 1'b1, 1'b0, 4'h0), rd);
      bus(1'b1, 4'h0, cw(t, 1'b1, 1'b0, 4'h4));
      stat(1'b0, 1'b0);
      tx_has_data <= 1'b1;
      host_u.hs_mode = 0;
      tok(uenpc_pkg::UENPC_TOK_IN, uenpc_pkg::UENPC_RSP_DATA, 1'b0, 1'b0);
      stat(1'b0, 1'b1);
      host_u.hs_mode = 1;
      tok(uenpc_pkg::UENPC_TOK_IN, uenpc_pkg::UENPC_RSP_DATA, 1'b0, 1'b1);
      stat(1'b0, 1'b1);
      tx_has_data <= 1'b0;
      tok(uenpc_pkg::UENPC_TOK_IN, uenpc_pkg::UENPC_RSP_NAK, 1'b0, 1'b0);
      @(posedge clk_sys);
      core_nak_req <= 1'b1;
      @(posedge clk_sys);
      core_nak_req <= 1'b0;
      stat(1'b1, 1'b1);
      tx_has_data <= 1'b1;
      tok(uenpc_pkg::UENPC_TOK_IN, uenpc_pkg::UENPC_RSP_NAK, 1'b0, 1'b0);
      bus(1'b1, 4'h0, cw(t, 1'b1, 1'b0, 4'h2));
   endtask

   // A token sent while a data packet awaits its late handshake gets no answer.
   task automatic t_busy();
      logic [5:0] s;
      host_u.hs_mode = 0;
      host_u.hs_delay = 10;
      tok(uenpc_pkg::UENPC_TOK_IN, uenpc_pkg::UENPC_RSP_DATA, 1'b0, 1'b1);
      host_u.send_token(uenpc_pkg::UENPC_TOK_IN, s);
      chk("busy token", 32'h0, {31'h0, s[5]});
      repeat (6) @(posedge clk_sys);
      stat(1'b0, 1'b0);
   endtask

   // Synchronous IN: frame parity in the toggle bit, zero-length answers.
   task automatic t_sync(input logic odd);
      host_u.hs_mode = 2;
      bus(1'b1, 4'h0, cw(uenpc_pkg::EP_SYNC, 1'b1, odd, 4'h0));
      stat(1'b0, odd);
      tx_has_data <= 1'b1;
      tok(uenpc_pkg::UENPC_TOK_IN, uenpc_pkg::UENPC_RSP_DATA, 1'b0, odd);
      tx_has_data <= 1'b0;
      tok(uenpc_pkg::UENPC_TOK_IN, uenpc_pkg::UENPC_RSP_ZLP, 1'b0, odd);
      bus(1'b1, 4'h0, cw(uenpc_pkg::EP_SYNC, 1'b1, odd, 4'h1));
      tx_has_data <= 1'b1;
      tok(uenpc_pkg::UENPC_TOK_IN, uenpc_pkg::UENPC_RSP_ZLP, 1'b0, odd);
      bus(1'b1, 4'h0, cw(uenpc_pkg::EP_SYNC, 1'b1, odd, 4'h2));
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////
   // Prints the counts and the verdict, then ends the run.
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Clock at 50 MHz.
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      close_out();
   end

   // Main sequence.
   initial begin
      rst = 1'b1;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      rx_has_room = 1'b0;
      tx_has_data = 1'b0;
      core_nak_req = 1'b0;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset();
      t_out();
      t_toggle(uenpc_pkg::EP_BULK, 0);
      t_toggle(uenpc_pkg::EP_INTR, 3);
      t_busy();
      t_sync(1'b0);
      t_sync(1'b1);
      close_out();
   end
endmodule
